// >>> eu_table_pkg.sv
// constants, codes and carriers of the per-channel conversion table store
package eu_table_pkg;

   // ***********************************************
   // sizes
   // ***********************************************
   localparam int NUM_CH    = 8;
   localparam int CH_W      = 3;
   localparam int SEG_WORDS = 512;
   localparam int SEG_W     = 9;
   localparam int MEM_AW    = CH_W + SEG_W;
   localparam int FRAC_W    = 7;
   localparam int RANGE_W   = 4;
   localparam int ID_W      = 7;
   localparam int LIB_AW    = ID_W + SEG_W;

   // ***********************************************
   // library layout, counts and reset values
   // ***********************************************
   localparam logic [ID_W-1:0]    STD_RES_ID   = 7'h00;
   localparam logic [ID_W-1:0]    TC_LIB_BASE  = 7'h40;
   localparam logic [SEG_W-1:0]   SEG_LAST     = 9'h1FF;
   localparam logic [SEG_W-1:0]   LIN_LAST     = 9'h001;
   localparam logic [MEM_AW-1:0]  MEM_LAST     = 12'hFFF;
   localparam logic [RANGE_W-1:0] RANGE_RST    = 4'h0;
   localparam logic [15:0]        REF_TEMP_RST = 16'h0000;
   localparam logic [15:0]        WORD_RST     = 16'h0000;
   localparam logic [LIB_AW-1:0]  LIB_ADDR_RST = 16'h0000;

   // ***********************************************
   // codes
   // ***********************************************
   typedef enum logic [2:0] {
      OP_STD_LINK    = 3'h0,
      OP_LOAD_LINEAR = 3'h1,
      OP_LOAD_PIECE  = 3'h2,
      OP_PIECE_DATA  = 3'h3,
      OP_LINK_CUST   = 3'h4,
      OP_LINK_TC     = 3'h5,
      OP_LINK_REF    = 3'h6,
      OP_RESET       = 3'h7
   } op_t;

   typedef enum logic [1:0] {
      KIND_NONE   = 2'h0,
      KIND_LINEAR = 2'h1,
      KIND_PIECE  = 2'h2
   } kind_t;

   typedef enum logic [2:0] {
      TC_E = 3'h0,
      TC_J = 3'h1,
      TC_K = 3'h2,
      TC_N = 3'h3,
      TC_R = 3'h4,
      TC_S = 3'h5,
      TC_T = 3'h6
   } tc_t;

   // ***********************************************
   // carriers
   // ***********************************************
   typedef struct packed {
      op_t                op;
      logic [NUM_CH-1:0]  ch_mask;
      logic [15:0]        arg0;
      logic [15:0]        arg1;
   } cmd_t;

   typedef struct packed {
      logic [CH_W-1:0]    ch;
      logic signed [15:0] vin;
   } conv_t;

   typedef struct packed {
      logic [CH_W-1:0]    ch;
      logic signed [31:0] value;
   } res_t;

endpackage : eu_table_pkg

// >>> eu_table_ram.sv
// single-port table store, one segment per channel, registered read data
`timescale 1ns/1ps
module eu_table_ram
(
   input  wire logic                          clk,
   input  wire logic                          we,
   input  wire logic [eu_table_pkg::MEM_AW-1:0] addr,
   input  wire logic [15:0]                   wdata,
   output logic      [15:0]                   rdata
);
   import eu_table_pkg::*;

   logic [15:0] mem [NUM_CH*SEG_WORDS];

   // no reset on the array: clearing is a sweep by the owner
   always_ff @(posedge clk)
   begin
      if (we)
         mem[addr] <= wdata;
      rdata <= mem[addr];
   end

endmodule : eu_table_ram

// >>> eu_table_store.sv
// per-channel engineering_unit table store and converter
// How it works
// [R1] standard link copies library table into channel
// [R2] each listed channel receives its own copy
// [R3] custom linear load sets channel registers, piecewise load writes straight into segments
// [R4] custom link only sets range and clears the thermocouple and reference roles, loads nothing
// [R5] reset command clears every table segment
// [R6] linear result is slope times input plus offset
// [R7] piecewise table holds 512 curve end-points
// [R8] between end-points result is linearly interpolated
// [R9] thermocouple type selects built-in compensation table
// [R10] compensation uses reference temperature at measurement
// [R11] reference channel result becomes reference temperature
// [R12] host supplies slope and offset per load
// [R13] host sends 512 sixteen-bit piecewise values
// [R14] host table range is power of two
// [R15] one active table per channel, replaced by load
// [R16] one storage segment for every channel
// [R17] resistance uses linear, temperature uses piecewise
// [R18] input scaled evenly across segments before interpolation
`timescale 1ns/1ps
module eu_table_store
(
   input  wire logic                                CLK_SYS,
   input  wire logic                                SYS_RST,
   input  wire logic                                CMD_VALID,
   output logic                                     CMD_READY,
   input  wire eu_table_pkg::cmd_t                  CMD,
   input  wire logic                                CONV_VALID,
   output logic                                     CONV_READY,
   input  wire eu_table_pkg::conv_t                 CONV,
   output logic                                     RES_VALID,
   output eu_table_pkg::res_t                       RES,
   output logic [eu_table_pkg::LIB_AW-1:0]          LIB_ADDR,
   input  wire logic [15:0]                         LIB_DATA,
   output logic [eu_table_pkg::NUM_CH*eu_table_pkg::RANGE_W-1:0] CH_RANGE
);
   import eu_table_pkg::*;

   // ***********************************************
   // state and helpers
   // ***********************************************
   typedef enum logic [9:0] {
      ST_IDLE    = 10'h001,
      ST_CLEAR   = 10'h002,
      ST_COPY_RD = 10'h004,
      ST_COPY_WR = 10'h008,
      ST_PW_WAIT = 10'h010,
      ST_PW_WR   = 10'h020,
      ST_CV_RJ   = 10'h040,
      ST_CV_RD0  = 10'h080,
      ST_CV_RD1  = 10'h100,
      ST_CV_OUT  = 10'h200
   } state_t;

   function automatic logic [CH_W:0] next_ch(input logic [NUM_CH-1:0] m,
                                             input logic [CH_W:0]   s);
      logic [CH_W:0] r;
      r = '0;
      for (int i = NUM_CH - 1; i >= 0; i--)
      begin
         if (m[i] && (i >= int'(s)))
            r = {1'b1, CH_W'(i)};
      end
      return r;
   endfunction : next_ch

   // [R18] offset binary, top bits pick one of equal segments
   function automatic logic [SEG_W-1:0] seg_index(input logic [15:0] v);
      return {~v[15], v[14:FRAC_W]};
   endfunction : seg_index

   function automatic logic [15:0] sat_add(input logic [15:0] a,
                                           input logic [15:0] b);
      logic [16:0] s;
      s = {a[15], a} + {b[15], b};
      if (s[16] != s[15])
         return s[16] ? 16'h8000 : 16'h7FFF;
      return s[15:0];
   endfunction : sat_add

   state_t                    state_q, state_d;
   logic [CH_W-1:0]           c_q, c_d;
   logic [SEG_W-1:0]          w_q, w_d;
   logic [NUM_CH-1:0]         mask_q, mask_d;
   logic [ID_W-1:0]           lib_id_q, lib_id_d;
   logic                      lin_q, lin_d;
   logic [15:0]               pw_word_q, pw_word_d;
   logic [LIB_AW-1:0]         lib_addr_q, lib_addr_d;
   kind_t                     kind_q [NUM_CH];
   kind_t                     kind_d [NUM_CH];
   logic signed [15:0]        slope_q [NUM_CH];
   logic signed [15:0]        slope_d [NUM_CH];
   logic signed [15:0]        offset_q [NUM_CH];
   logic signed [15:0]        offset_d [NUM_CH];
   logic [RANGE_W-1:0]        range_q [NUM_CH];
   logic [RANGE_W-1:0]        range_d [NUM_CH];
   logic [2:0]                tc_q [NUM_CH];
   logic [2:0]                tc_d [NUM_CH];
   logic [NUM_CH-1:0]         is_tc_q, is_tc_d, is_ref_q, is_ref_d;
   logic [15:0]               ref_temp_q, ref_temp_d;
   logic [CH_W-1:0]           cv_ch_q, cv_ch_d;
   logic signed [15:0]        vin_q, vin_d, y0_q, y0_d, y1;
   res_t                      res_q, res_d;
   logic                      res_valid_q, res_valid_d;
   logic [CH_W:0]             nc, hit, first;
   logic signed [16:0]        diff;
   logic signed [24:0]        prod;
   logic signed [31:0]        lin_val, piece_val;
   logic                      mem_we;
   logic [MEM_AW-1:0]         mem_addr;
   logic [15:0]               mem_wdata, mem_rdata;

   // [R16] one segment per channel
   eu_table_ram u_ram
   (
      .clk   (CLK_SYS),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (mem_wdata),
      .rdata (mem_rdata)
   );

   assign CMD_READY  = (state_q == ST_IDLE) || (state_q == ST_PW_WAIT);
   assign CONV_READY = (state_q == ST_IDLE) && !CMD_VALID;
   assign RES_VALID  = res_valid_q;
   assign RES        = res_q;
   assign LIB_ADDR   = lib_addr_q;

   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_range
      assign CH_RANGE[g*RANGE_W +: RANGE_W] = range_q[g];
   end

   // ***********************************************
   // next state
   // ***********************************************
   always_comb
   begin
      state_d = state_q;   c_d = c_q;   w_d = w_q;   mask_d = mask_q;
      lib_id_d = lib_id_q; lin_d = lin_q; pw_word_d = pw_word_q;
      lib_addr_d = lib_addr_q;
      kind_d = kind_q; slope_d = slope_q; offset_d = offset_q;
      range_d = range_q; tc_d = tc_q; is_tc_d = is_tc_q; is_ref_d = is_ref_q;
      ref_temp_d = ref_temp_q; cv_ch_d = cv_ch_q; vin_d = vin_q; y0_d = y0_q;
      res_d = res_q; res_valid_d = 1'b0;
      mem_we = 1'b0; mem_addr = {c_q, w_q}; mem_wdata = WORD_RST;
      nc  = next_ch(mask_q, {1'b0, c_q} + 1'b1);
      hit = next_ch(CMD.ch_mask, '0);
      first = next_ch(mask_q, '0);
      y1  = mem_rdata;
      // [R8] interpolate between neighbouring end-points
      diff = {y1[15], y1} - {y0_q[15], y0_q};
      prod = diff * $signed({1'b0, vin_q[FRAC_W-1:0]});
      piece_val = 32'(y0_q) + 32'(prod >>> FRAC_W);
      // [R6] slope times input plus offset
      lin_val = 32'(slope_q[cv_ch_q]) * 32'(vin_q) + 32'(offset_q[cv_ch_q]);
      case (state_q)
         ST_IDLE:
         begin
            if (CMD_VALID)
            begin
               case (CMD.op)
                  OP_RESET:
                  begin
                     // [R5] tables lost, sweep clears all segments
                     c_d = '0;
                     w_d = '0;
                     state_d = ST_CLEAR;
                     ref_temp_d = REF_TEMP_RST;
                     is_tc_d = '0;
                     is_ref_d = '0;
                     for (int i = 0; i < NUM_CH; i++)
                     begin
                        kind_d[i] = KIND_NONE;
                        range_d[i] = RANGE_RST;
                        slope_d[i] = WORD_RST;
                        offset_d[i] = WORD_RST;
                     end
                  end
                  OP_STD_LINK:
                  begin
                     if (hit[CH_W])
                     begin
                        mask_d = CMD.ch_mask;
                        c_d = hit[CH_W-1:0];
                        w_d = '0;
                        lib_id_d = CMD.arg0[ID_W-1:0];
                        // [R17] resistance library entry is linear
                        lin_d = (CMD.arg0[ID_W-1:0] == STD_RES_ID);
                        state_d = ST_COPY_RD;
                     end
                  end
                  OP_LOAD_LINEAR:
                  begin
                     // [R3] custom linear load straight into channel
                     for (int i = 0; i < NUM_CH; i++)
                        if (CMD.ch_mask[i])
                        begin
                           kind_d[i] = KIND_LINEAR;
                           slope_d[i] = CMD.arg0;
                           offset_d[i] = CMD.arg1;
                        end
                  end
                  OP_LOAD_PIECE:
                  begin
                     if (hit[CH_W])
                     begin
                        mask_d = CMD.ch_mask;
                        w_d = '0;
                        state_d = ST_PW_WAIT;
                     end
                  end
                  default:
                  begin
                     // [R4] links only choose range and role
                     for (int i = 0; i < NUM_CH; i++)
                        if (CMD.ch_mask[i] && CMD.op != OP_PIECE_DATA)
                        begin
                           range_d[i] = CMD.arg1[RANGE_W-1:0];
                           // [R9] wire type kept for compensation
                           is_tc_d[i] = (CMD.op == OP_LINK_TC);
                           is_ref_d[i] = (CMD.op == OP_LINK_REF);
                           if (CMD.op == OP_LINK_TC)
                              tc_d[i] = CMD.arg0[2:0];
                        end
                  end
               endcase
            end
            else if (CONV_VALID)
            begin
               cv_ch_d = CONV.ch;
               vin_d = CONV.vin;
               if (kind_q[CONV.ch] != KIND_PIECE)
                  state_d = ST_CV_OUT;
               else if (is_tc_q[CONV.ch])
                  state_d = ST_CV_RJ;
               else
                  state_d = ST_CV_RD0;
            end
         end
         ST_CLEAR:
         begin
            mem_we = 1'b1;
            {c_d, w_d} = MEM_AW'({c_q, w_q} + 1'b1);
            if ({c_q, w_q} == MEM_LAST)
               state_d = ST_IDLE;
         end
         ST_COPY_RD:
         begin
            lib_addr_d = {lib_id_q, w_q};
            state_d = ST_COPY_WR;
         end
         ST_COPY_WR:
         begin
            // [R1] library word into the channel's own copy
            if (!lin_q)
               mem_we = 1'b1;
            mem_wdata = LIB_DATA;
            if (lin_q && w_q == '0)
               slope_d[c_q] = LIB_DATA;
            if (lin_q && w_q == LIN_LAST)
               offset_d[c_q] = LIB_DATA;
            state_d = ST_COPY_RD;
            w_d = w_q + 1'b1;
            if (w_q == (lin_q ? LIN_LAST : SEG_LAST))
            begin
               // [R15] new table replaces the old one
               kind_d[c_q] = lin_q ? KIND_LINEAR : KIND_PIECE;
               is_tc_d[c_q] = 1'b0;
               is_ref_d[c_q] = 1'b0;
               w_d = '0;
               // [R2] repeat the copy for every listed channel
               if (nc[CH_W])
                  c_d = nc[CH_W-1:0];
               else
                  state_d = ST_IDLE;
            end
         end
         ST_PW_WAIT:
         begin
            // any other command abandons the load
            if (CMD_VALID)
            begin
               state_d = ST_IDLE;
               if (CMD.op == OP_PIECE_DATA)
               begin
                  pw_word_d = CMD.arg0;
                  c_d = first[CH_W-1:0];
                  state_d = ST_PW_WR;
               end
            end
         end
         ST_PW_WR:
         begin
            // [R3] each word written into all listed segments
            mem_we = 1'b1;
            mem_wdata = pw_word_q;
            if (nc[CH_W])
               c_d = nc[CH_W-1:0];
            else if (w_q == SEG_LAST)
            begin
               state_d = ST_IDLE;
               for (int i = 0; i < NUM_CH; i++)
                  if (mask_q[i])
                     kind_d[i] = KIND_PIECE;
            end
            else
            begin
               w_d = w_q + 1'b1;
               state_d = ST_PW_WAIT;
            end
         end
         ST_CV_RJ:
         begin
            // [R10] reference temperature as it stands now
            lib_addr_d = {ID_W'(TC_LIB_BASE + ID_W'(tc_q[cv_ch_q])),
                          ref_temp_q[15:FRAC_W]};
            state_d = ST_CV_RD0;
         end
         ST_CV_RD0:
         begin
            if (is_tc_q[cv_ch_q])
               vin_d = sat_add(vin_q, LIB_DATA);
            mem_addr = {cv_ch_q, seg_index(vin_d)};
            state_d = ST_CV_RD1;
         end
         ST_CV_RD1:
         begin
            // [R7] last segment reuses its end-point
            y0_d = mem_rdata;
            mem_addr = {cv_ch_q, seg_index(vin_q)};
            if (seg_index(vin_q) != SEG_LAST)
               mem_addr = {cv_ch_q, seg_index(vin_q) + 1'b1};
            state_d = ST_CV_OUT;
         end
         ST_CV_OUT:
         begin
            res_valid_d = 1'b1;
            res_d.ch = cv_ch_q;
            case (kind_q[cv_ch_q])
               KIND_PIECE:  res_d.value = piece_val;
               KIND_LINEAR: res_d.value = lin_val;
               default:     res_d.value = 32'(vin_q);
            endcase
            // [R11] reference channel feeds compensation
            if (is_ref_q[cv_ch_q])
               ref_temp_d = res_d.value[15:0];
            state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         // reset also sweeps the segments before taking commands
         state_q <= ST_CLEAR;  c_q <= '0;  w_q <= '0;  mask_q <= '0;
         lib_id_q <= '0; lin_q <= 1'b0; pw_word_q <= WORD_RST;
         lib_addr_q <= LIB_ADDR_RST; is_tc_q <= '0; is_ref_q <= '0;
         ref_temp_q <= REF_TEMP_RST; cv_ch_q <= '0; vin_q <= WORD_RST;
         y0_q <= WORD_RST; res_q <= '0; res_valid_q <= 1'b0;
         for (int i = 0; i < NUM_CH; i++)
         begin
            kind_q[i] <= KIND_NONE;  slope_q[i] <= WORD_RST;
            offset_q[i] <= WORD_RST; range_q[i] <= RANGE_RST;
            tc_q[i] <= 3'h0;
         end
      end
      else
      begin
         state_q <= state_d;  c_q <= c_d;  w_q <= w_d;  mask_q <= mask_d;
         lib_id_q <= lib_id_d; lin_q <= lin_d; pw_word_q <= pw_word_d;
         lib_addr_q <= lib_addr_d; is_tc_q <= is_tc_d; is_ref_q <= is_ref_d;
         ref_temp_q <= ref_temp_d; cv_ch_q <= cv_ch_d; vin_q <= vin_d;
         y0_q <= y0_d; res_q <= res_d; res_valid_q <= res_valid_d;
         kind_q <= kind_d; slope_q <= slope_d; offset_q <= offset_d;
         range_q <= range_d; tc_q <= tc_d;
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   sequence pc_start;
      state_q == ST_IDLE && CONV_VALID && CONV_READY
         && kind_q[CONV.ch] == KIND_PIECE && !is_tc_q[CONV.ch];
   endsequence
   sequence pc_walk;
      state_q == ST_CV_RD0 ##1 state_q == ST_CV_RD1 ##1 state_q == ST_CV_OUT ##1 RES_VALID;
   endsequence

   clear_zero_a: assert property ( // [R5]
      state_q == ST_CLEAR |-> mem_we && mem_wdata == WORD_RST)
      else $error("clear sweep writes nonzero");
   copy_lib_a: assert property ( // [R1]
      state_q == ST_COPY_WR && !lin_q |-> mem_we && mem_wdata == LIB_DATA
         && mem_addr == {c_q, w_q} && LIB_ADDR == {lib_id_q, w_q})
      else $error("library copy word misplaced");
   copy_each_a: assert property ( // [R2]
      state_q == ST_COPY_WR && w_q == SEG_LAST && !lin_q && nc[CH_W]
         |=> state_q == ST_COPY_RD && w_q == '0 && c_q == $past(nc[CH_W-1:0]))
      else $error("copy skipped a listed channel");
   pw_write_a: assert property ( // [R3]
      state_q == ST_PW_WR |-> mem_we && mem_wdata == pw_word_q)
      else $error("piecewise word not written");
   link_cust_a: assert property ( // [R4]
      state_q == ST_IDLE && CMD_VALID && CMD.op == OP_LINK_CUST
         |-> !mem_we ##1 state_q == ST_IDLE && !mem_we)
      else $error("custom link touched tables");
   lin_conv_a: assert property ( // [R6]
      state_q == ST_IDLE && CONV_VALID && CONV_READY && kind_q[CONV.ch] == KIND_LINEAR
         |=> ##1 RES_VALID && RES.value == 32'(slope_q[$past(CONV.ch, 2)])
            * 32'($past(CONV.vin, 2)) + 32'(offset_q[$past(CONV.ch, 2)]))
      else $error("linear result wrong");
   piece_seq_a: assert property ( // [R8]
      pc_start |=> pc_walk)
      else $error("piecewise conversion sequence broken");
   seg_end_a: assert property ( // [R7]
      state_q == ST_CV_OUT && kind_q[cv_ch_q] == KIND_PIECE && vin_q[FRAC_W-1:0] == '0
         |=> RES.value == 32'($past(y0_q)))
      else $error("end-point value not returned");
   tc_ref_a: assert property ( // [R10]
      state_q == ST_CV_RJ |=> LIB_ADDR[SEG_W-1:0] == $past(ref_temp_q[15:FRAC_W])
         && LIB_ADDR[LIB_AW-1:SEG_W] == ID_W'(TC_LIB_BASE + ID_W'($past(tc_q[cv_ch_q]))))
      else $error("compensation lookup wrong");
   ref_upd_a: assert property ( // [R11]
      RES_VALID && is_ref_q[RES.ch] |-> ref_temp_q == RES.value[15:0])
      else $error("reference temperature not taken");

endmodule : eu_table_store

// >>> eu_table_store_tb.sv
// self-checking bench for the conversion table store
`timescale 1ns/1ps
module eu_table_store_tb;
   import eu_table_pkg::*;
   logic        clk, rst, cmd_valid, cmd_ready, conv_valid, conv_ready, res_valid;
   cmd_t        cmd;
   conv_t       conv;
   res_t        res;
   logic [15:0] lib_addr, lib_data;
   logic [31:0] ch_range, a, b;
   int          n_mismatch, tests_run, refv, r;
   int          kind[8], slope[8], offs[8], tc[8], isref[8], tab[8][512];
   int          vs[4] = '{-32768, 32767, -129, 128};

   eu_table_store eu_table_store_inst (.CLK_SYS(clk), .SYS_RST(rst), .CMD_VALID(cmd_valid),
      .CMD_READY(cmd_ready), .CMD(cmd), .CONV_VALID(conv_valid), .CONV_READY(conv_ready),
      .CONV(conv), .RES_VALID(res_valid), .RES(res), .LIB_ADDR(lib_addr),
      .LIB_DATA(lib_data), .CH_RANGE(ch_range));
   lib_rom_model lib_rom_model_inst (.addr(lib_addr), .data(lib_data));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic int lib(int x);
      return $signed(16'(x ^ 5));
   endfunction : lib

   function automatic int model(int c, int v);
      int i, f, y0, y1;
      if (tc[c] >= 0)
      begin
         v = v + lib(((64 + tc[c]) << 9) | ((refv & 16'hFFFF) >> 7));
         v = (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
      end
      if (kind[c] == 1)
         return slope[c] * v + offs[c];
      if (kind[c] != 2)
         return v;
      i = (v + 32768) >> 7;
      f = v & 127;
      y0 = tab[c][i];
      y1 = (i == 511) ? y0 : tab[c][i + 1];
      return y0 + (((y1 - y0) * f) >>> 7);
   endfunction : model

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic wait_sig(input int w);
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
         if (n > 9000)
         begin
            n_mismatch++;
            tally_and_finish();
         end
      end
      while ((w == 0 ? cmd_ready : w == 1 ? conv_ready : res_valid) !== 1'b1);
   endtask : wait_sig

   task automatic setk(input int c, input int k, input int s, input int o);
      kind[c] = k;
      slope[c] = s;
      offs[c] = o;
      tc[c] = -1;
      isref[c] = 0;
   endtask : setk

   task automatic clr;
      refv = 0;
      for (int c = 0; c < 8; c++)
         setk(c, 0, 0, 0);
   endtask : clr

   // request held until the edge that sees ready, then an idle edge
   task automatic send(input op_t o, input logic [7:0] m, input int x, input int y);
      cmd_valid <= 1'b1;
      cmd <= '{o, m, x[15:0], y[15:0]};
      wait_sig(0);
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(posedge clk);
   endtask : send

   task automatic cv(input int c, input int v);
      int e;
      v = $signed(v[15:0]);
      e = model(c, v);
      conv_valid <= 1'b1;
      conv <= '{c[2:0], v[15:0]};
      wait_sig(1);
      @(posedge clk);
      conv_valid <= 1'b0;
      wait_sig(2);
      chk(res.value, e);
      chk(32'(res.ch), c);
      if (isref[c])
         refv = e;
      @(posedge clk);
   endtask : cv

   initial
   begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      conv_valid = 1'b0;
      cmd = '0;
      conv = '0;
      n_mismatch = 0;
      tests_run = 0;
      clr();
      r = $urandom(32'h4ED7);
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cv(3, $urandom);
      $display("test empty done");
      a = $urandom;
      b = $urandom;
      send(OP_LOAD_LINEAR, 8'h05, a, b);
      setk(0, 1, $signed(a[15:0]), $signed(b[15:0]));
      setk(2, 1, $signed(a[15:0]), $signed(b[15:0]));
      for (int c = 0; c < 3; c++)
         cv(c, $urandom);
      $display("test linear done");
      send(OP_LINK_CUST, 8'h04, 0, 16'h000B);
      cv(2, $urandom);
      chk(ch_range, 32'h00000B00);
      $display("test link done");
      // piecewise load, arg1 of 8 sets no range, word 0 first
      send(OP_LOAD_PIECE, 8'h82, 0, 8);
      for (int k = 0; k < 512; k++)
      begin
         a = $urandom;
         tab[1][k] = $signed(a[15:0]);
         tab[7][k] = tab[1][k];
         send(OP_PIECE_DATA, 8'h82, a, 0);
      end
      setk(1, 2, 0, 0);
      setk(7, 2, 0, 0);
      for (int i = 0; i < 4; i++)
         cv(1, vs[i]);
      cv(7, $urandom);
      $display("test piecewise done");
      send(OP_STD_LINK, 8'h30, 0, 0);
      setk(4, 1, lib(0), lib(1));
      setk(5, 1, lib(0), lib(1));
      // one piecewise copy per channel, channel 5 replaced
      send(OP_STD_LINK, 8'h60, 1, 0);
      for (int k = 0; k < 512; k++)
      begin
         tab[6][k] = lib(512 + k);
         tab[5][k] = tab[6][k];
      end
      setk(5, 2, 0, 0);
      setk(6, 2, 0, 0);
      for (int c = 1; c < 7; c++)
         cv(c, $urandom);
      $display("test library done");
      // reference channel then every wire type
      send(OP_LINK_REF, 8'h80, 0, 2);
      isref[7] = 1;
      cv(7, $urandom);
      for (int t = 0; t < 7; t++)
      begin
         send(OP_LINK_TC, 8'h02, t, 1);
         tc[1] = t;
         cv(1, $urandom);
      end
      $display("test thermocouple done");
      send(OP_RESET, 8'h00, 0, 0);
      clr();
      for (int c = 0; c < 8; c++)
         cv(c, $urandom);
      chk(ch_range, 32'h0);
      $display("test clear done");
      tally_and_finish();
   end
endmodule : eu_table_store_tb

// >>> lib_rom_model.sv
// non-volatile library model answering one table word per address
`timescale 1ns/1ps
module lib_rom_model
(
   input  wire logic [15:0] addr,
   output logic      [15:0] data
);
   // combinational word, id 0 words 0/1 give slope and offset
   // pattern differs per id so a wrong table id shows up in results
   assign data = addr ^ 16'h0005;
endmodule : lib_rom_model
